/* ucf_defs.vh */
`ifndef UCF_DEFS_VH
`define UCF_DEFS_VH

// ****************
// register offsets
// ****************
`define UCF_OFS_CTRL 8'h00
`define UCF_OFS_DELIM 8'h04
`define UCF_OFS_STATUS 8'h08
`define UCF_OFS_IRQ_STAT 8'h0c
`define UCF_OFS_IRQ_MASK 8'h10
`define UCF_OFS_INFO 8'h14

// ****************
// fields and reset values
// ****************
`define UCF_CTRL_TERM_BIT 0
`define UCF_CTRL_RST 1'h0
`define UCF_DELIM_RST 8'h2c
`define UCF_PRINT_LO 8'h20
`define UCF_PRINT_HI 8'h7e
`define UCF_NULL 8'h00
`define UCF_IRQ_CMD_BIT 0
`define UCF_IRQ_RSP_BIT 1
`define UCF_IRQ_ERR_BIT 2
`define UCF_IRQ_W 3
`define UCF_IRQ_RST 3'h0
`define UCF_STATUS_RST 8'h00
`define UCF_ERR_BITS 8'h5e

// ****************
// response item kinds
// ****************
`define UCF_KIND_CHAR 3'h0
`define UCF_KIND_SEP 3'h1
`define UCF_KIND_VEND 3'h2
`define UCF_KIND_BIN 3'h3
`define UCF_KIND_DONE 3'h4
`endif

/* ucf_framer.v */
`include "ucf_defs.vh"
module ucf_framer (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output wire irq,
	input wire usb_hs,
	input wire ep1_valid,
	input wire [7:0] ep1_data,
	output wire ep1_ready,
	output wire cmd_valid,
	output wire [7:0] cmd_data,
	output wire cmd_end,
	input wire rsp_valid,
	input wire [2:0] rsp_kind,
	input wire [15:0] rsp_data,
	output wire rsp_ready,
	output wire ep2_valid,
	output wire [7:0] ep2_data,
	input wire ep2_ready,
	input wire [7:1] ev_status,
	input wire [7:0] ovl_byte
);

	localparam ST_IDLE = 3'h0;
	localparam ST_BLO = 3'h1;
	localparam ST_STAT = 3'h2;
	localparam ST_OVL = 3'h3;
	localparam ST_FIN = 3'h4;

	// ****************
	// state
	// ****************
	reg [31:0] prdata_ff;
	reg pready_ff;
	reg pslverr_ff;
	reg irq_ff;
	reg ep1_ready_ff;
	reg cmd_valid_ff;
	reg [7:0] cmd_data_ff;
	reg cmd_end_ff;
	reg rsp_ready_ff;
	reg ep2_valid_ff;
	reg [7:0] ep2_data_ff;
	reg [2:0] st_ff;
	reg [7:0] lo_ff;
	reg term_ff;
	reg [7:0] delim_ff;
	reg [7:0] status_ff;
	reg [`UCF_IRQ_W-1:0] irq_stat_ff;
	reg [`UCF_IRQ_W-1:0] irq_mask_ff;
	reg in_cmd_ff;

	reg [2:0] nxt_st;
	reg nxt_ep2_valid;
	reg [7:0] nxt_ep2_data;
	reg [7:0] nxt_lo;
	reg rsp_done;
	reg [31:0] nxt_rdata;
	reg nxt_err;

	wire setup_ph = psel && !penable && !pready_ff;
	wire acc_done = psel && penable && pready_ff;
	wire wr_acc = acc_done && pwrite;
	wire rd_acc = acc_done && !pwrite;
	wire slot_free = !ep2_valid_ff || ep2_ready;
	wire rsp_take = rsp_valid && rsp_ready_ff;
	wire ep1_take = ep1_valid && ep1_ready_ff;
	wire cmd_null = ep1_take && (ep1_data == `UCF_NULL);
	wire cmd_first = ep1_take && !in_cmd_ff;

	function hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	function printable;
		input [7:0] c;
		begin
			printable = (c >= `UCF_PRINT_LO) && (c <= `UCF_PRINT_HI);
		end
	endfunction

	// ****************
	// response sequencer
	// ****************
	// one byte slot toward endpoint 2; a byte stays put until the endpoint takes it
	always @* begin
		nxt_st = st_ff;
		nxt_ep2_valid = ep2_valid_ff && !ep2_ready;
		nxt_ep2_data = ep2_data_ff;
		nxt_lo = lo_ff;
		rsp_done = 1'b0;
		case (st_ff)
			ST_IDLE: begin
				if (rsp_take) begin
					nxt_ep2_valid = 1'b1;
					case (rsp_kind)
						`UCF_KIND_CHAR: begin
							nxt_ep2_data = rsp_data[7:0];
						end
						`UCF_KIND_SEP: begin
							nxt_ep2_data = delim_ff;
						end
						`UCF_KIND_VEND: begin
							nxt_ep2_data = `UCF_NULL;
						end
						`UCF_KIND_BIN: begin
							// raw data may hold nulls, so no framing inside a point
							nxt_ep2_data = rsp_data[15:8];
							nxt_lo = rsp_data[7:0];
							nxt_st = ST_BLO;
						end
						`UCF_KIND_DONE: begin
							// terminator is sent even when no data came
							nxt_ep2_data = `UCF_NULL;
							nxt_st = term_ff ? ST_STAT : ST_FIN;
						end
						default: begin
							nxt_ep2_valid = ep2_valid_ff && !ep2_ready;
						end
					endcase
				end
			end
			ST_BLO: begin
				if (slot_free) begin
					nxt_ep2_valid = 1'b1;
					nxt_ep2_data = lo_ff;
					nxt_st = ST_IDLE;
				end
			end
			ST_STAT: begin
				if (slot_free) begin
					nxt_ep2_valid = 1'b1;
					nxt_ep2_data = status_ff;
					nxt_st = ST_OVL;
				end
			end
			ST_OVL: begin
				if (slot_free) begin
					nxt_ep2_valid = 1'b1;
					nxt_ep2_data = ovl_byte;
					nxt_st = ST_FIN;
				end
			end
			ST_FIN: begin
				// one beat after the last byte is loaded, then done is flagged
				rsp_done = 1'b1;
				nxt_st = ST_IDLE;
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= ST_IDLE;
			ep2_valid_ff <= 1'b0;
			ep2_data_ff <= 8'h00;
			lo_ff <= 8'h00;
			rsp_ready_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			ep2_valid_ff <= nxt_ep2_valid;
			ep2_data_ff <= nxt_ep2_data;
			lo_ff <= nxt_lo;
			// ready only in idle with a free slot; dropped after each taken item
			rsp_ready_ff <= (nxt_st == ST_IDLE) && !nxt_ep2_valid && !rsp_take;
		end
	end

	// ****************
	// command intake
	// ****************
	// byte stream is speed blind: full and high speed framing both end here
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ep1_ready_ff <= 1'b0;
			cmd_valid_ff <= 1'b0;
			cmd_data_ff <= 8'h00;
			cmd_end_ff <= 1'b0;
			in_cmd_ff <= 1'b0;
		end else begin
			// no back pressure: the interpreter takes a byte every cycle
			ep1_ready_ff <= 1'b1;
			cmd_valid_ff <= ep1_take && !cmd_null;
			cmd_data_ff <= ep1_take ? ep1_data : cmd_data_ff;
			cmd_end_ff <= cmd_null;
			// tracks whether the next byte opens a new command
			if (ep1_take) begin
				in_cmd_ff <= !cmd_null;
			end
		end
	end

	// ****************
	// status byte
	// ****************
	// bit 0 marks completion, cleared as a new command starts; sets beat clears
	wire done_take = (st_ff == ST_IDLE) && rsp_take && (rsp_kind == `UCF_KIND_DONE);
	wire [7:0] stat_set = {ev_status, done_take};
	wire [7:0] stat_w1c = (wr_acc && hit(paddr, `UCF_OFS_STATUS)) ? pwdata[7:0] : 8'h00;
	// completion and a new first byte in one cycle: completion wins
	wire [7:0] stat_clr = stat_w1c | {7'h00, cmd_first};
	// only a newly raised error bit counts; a held one does not refire the interrupt
	wire [7:0] err_bits = `UCF_ERR_BITS;
	wire err_evt = |(ev_status & ~status_ff[7:1] & err_bits[7:1]);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= `UCF_STATUS_RST;
		end else begin
			status_ff <= (status_ff & ~stat_clr) | stat_set;
		end
	end

	// ****************
	// configuration and interrupts
	// ****************
	wire [`UCF_IRQ_W-1:0] irq_set = {err_evt, rsp_done, cmd_null};
	wire irq_rd = rd_acc && hit(paddr, `UCF_OFS_IRQ_STAT);
	// a read clears only what it showed; a set landing in the setup cycle is kept
	wire [`UCF_IRQ_W-1:0] irq_seen = irq_rd ? prdata_ff[`UCF_IRQ_W-1:0] : {`UCF_IRQ_W{1'b0}};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			term_ff <= `UCF_CTRL_RST;
			delim_ff <= `UCF_DELIM_RST;
			irq_stat_ff <= `UCF_IRQ_RST;
			irq_mask_ff <= `UCF_IRQ_RST;
			irq_ff <= 1'b0;
		end else begin
			if (wr_acc && hit(paddr, `UCF_OFS_CTRL)) begin
				term_ff <= pwdata[`UCF_CTRL_TERM_BIT];
			end
			// non printing delimiters are refused, the old one stays
			if (wr_acc && hit(paddr, `UCF_OFS_DELIM) && printable(pwdata[7:0])) begin
				delim_ff <= pwdata[7:0];
			end
			if (wr_acc && hit(paddr, `UCF_OFS_IRQ_MASK)) begin
				irq_mask_ff <= pwdata[`UCF_IRQ_W-1:0];
			end
			irq_stat_ff <= (irq_stat_ff & ~irq_seen) | irq_set;
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
		end
	end

	// ****************
	// apb slave
	// ****************
	// no wait state: data is captured in setup, answer shown in the first access cycle
	always @* begin
		nxt_rdata = 32'h00000000;
		nxt_err = 1'b0;
		case (paddr)
			`UCF_OFS_CTRL: nxt_rdata = {31'h00000000, term_ff};
			`UCF_OFS_DELIM: nxt_rdata = {24'h000000, delim_ff};
			`UCF_OFS_STATUS: nxt_rdata = {24'h000000, status_ff};
			`UCF_OFS_IRQ_STAT: nxt_rdata = {29'h00000000, irq_stat_ff};
			`UCF_OFS_IRQ_MASK: nxt_rdata = {29'h00000000, irq_mask_ff};
			`UCF_OFS_INFO: nxt_rdata = {27'h0000000, st_ff, rsp_ready_ff, usb_hs};
			// unmapped offsets answer with an error and read as zero
			default: nxt_err = 1'b1;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			pready_ff <= setup_ph;
			pslverr_ff <= setup_ph && nxt_err;
			prdata_ff <= (setup_ph && !pwrite) ? nxt_rdata : 32'h00000000;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq = irq_ff;
	assign ep1_ready = ep1_ready_ff;
	assign cmd_valid = cmd_valid_ff;
	assign cmd_data = cmd_data_ff;
	assign cmd_end = cmd_end_ff;
	assign rsp_ready = rsp_ready_ff;
	assign ep2_valid = ep2_valid_ff;
	assign ep2_data = ep2_data_ff;

endmodule // ucf_framer

/* ucf_checker.sv */
module ucf_checker (
	input wire logic pclk, presetn, ep1_valid, ep1_ready, cmd_valid, cmd_end,
	input wire logic rsp_valid, rsp_ready, ep2_valid, ep2_ready,
	input wire logic [7:0] ep1_data, cmd_data, ep2_data,
	input wire logic [2:0] rsp_kind,
	input wire logic [15:0] rsp_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] rsp_data_ff;
	wire t1 = ep1_valid && ep1_ready;
	wire tk = rsp_valid && rsp_ready;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// copy of the taken item, a slice of a past value is not portable
	always @(posedge pclk) rsp_data_ff <= rsp_data;
	// low byte of a taken point, for the second byte of a binary dump
	logic [7:0] lo_exp_ff;
	always @(posedge pclk) if (tk && rsp_kind == 3'h3) lo_exp_ff <= rsp_data[7:0];
	chk_cmd_byte: assert property (t1 && ep1_data != 8'h00
		|=> cmd_valid && !cmd_end && cmd_data == $past(ep1_data)) else $error("cmd byte");
	chk_cmd_null: assert property (t1 && ep1_data == 8'h00
		|=> cmd_end && !cmd_valid) else $error("cmd end");
	chk_ep2_hold: assert property (ep2_valid && !ep2_ready
		|=> ep2_valid && $stable(ep2_data)) else $error("ep2 hold");
	chk_char_out: assert property (tk && rsp_kind == 3'h0
		|=> ep2_valid && ep2_data == rsp_data_ff[7:0]) else $error("char byte");
	chk_vend_null: assert property (tk && rsp_kind == 3'h2
		|=> ep2_valid && ep2_data == 8'h00) else $error("value end");
	chk_bin_high: assert property (tk && rsp_kind == 3'h3
		|=> ep2_valid && ep2_data == rsp_data_ff[15:8]) else $error("bin order");
	chk_bin_low: assert property (tk && rsp_kind == 3'h3 ##1 ep2_valid && ep2_ready
		|=> ep2_valid && ep2_data == lo_exp_ff) else $error("bin low");
	chk_term_null: assert property (tk && rsp_kind == 3'h4
		|=> ep2_valid && ep2_data == 8'h00) else $error("term null");
	chk_no_overlap: assert property (ep2_valid |-> !rsp_ready) else $error("overlap");
	chk_ready_drop: assert property (tk |=> !rsp_ready) else $error("ready drop");
endmodule // ucf_checker

/* ucf_host.sv */
module ucf_host (
	input wire logic pclk, presetn, ep1_ready, ep2_valid,
	input wire logic [7:0] ep2_data,
	output logic ep1_valid = 1'b0,
	output logic [7:0] ep1_data = 8'h00,
	output logic ep2_ready = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx[$];
	logic stall = 1'b0;
	int n_tmo = 0;
	// slow mode accepts every other cycle, stretching each byte
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) ep2_ready <= 1'b0;
		else ep2_ready <= stall ? ~ep2_ready : 1'b1;
	end
	always @(posedge pclk) if (ep2_valid && ep2_ready) rx.push_back(ep2_data);
	task send(input logic [7:0] b);
		int i;
		@(posedge pclk);
		ep1_valid <= 1'b1;
		ep1_data <= b;
		@(posedge pclk);
		for (i = 0; i < 20 && !ep1_ready; i++) @(posedge pclk);
		if (!ep1_ready) n_tmo++;
		ep1_valid <= 1'b0;
		ep1_data <= ~b; // a released line shows no stale byte
	endtask
endmodule // ucf_host

/* testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [2:0] k; logic [15:0] d; logic [1:0] n; logic [15:0] e;} ucf_row_t;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic usb_hs = 1'b1, rsp_valid = 1'b0, err;
	logic [7:0] paddr = 8'h00, ovl_byte = 8'h5a, last_cmd = 8'h00;
	logic [31:0] pwdata = 32'h0, q;
	logic [2:0] rsp_kind = 3'h0;
	logic [15:0] rsp_data = 16'h0;
	logic [7:1] ev_status = 7'h00;
	wire [31:0] prdata;
	wire pready, pslverr, irq, ep1_valid, ep1_ready, cmd_valid, cmd_end;
	wire rsp_ready, ep2_valid, ep2_ready;
	wire [7:0] ep1_data, cmd_data, ep2_data;
	int n_mismatch = 0, checks = 0, n_end = 0;
	ucf_row_t rows[6] = '{
		'{3'h0, 16'h0031, 2'h1, 16'h0031},
		'{3'h1, 16'h0000, 2'h1, 16'h002c},
		'{3'h2, 16'h0000, 2'h1, 16'h0000},
		'{3'h3, 16'ha500, 2'h2, 16'ha500},
		'{3'h4, 16'h0000, 2'h1, 16'h0000},
		'{3'h5, 16'h1234, 2'h0, 16'h0000}
	};
	ucf_framer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .irq, .usb_hs, .ep1_valid, .ep1_data, .ep1_ready, .cmd_valid, .cmd_data,
		.cmd_end, .rsp_valid, .rsp_kind, .rsp_data, .rsp_ready, .ep2_valid, .ep2_data, .ep2_ready,
		.ev_status, .ovl_byte);
	ucf_host i_host (.pclk, .presetn, .ep1_ready, .ep2_valid, .ep2_data, .ep1_valid, .ep1_data,
		.ep2_ready);
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) if (cmd_valid) last_cmd <= cmd_data;
	always @(posedge pclk) if (cmd_end) n_end <= n_end + 1;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task summarize;
		$display("checks=%0d mismatches=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task tmo;
		chk(32'h1, 32'h0); // a bounded wait ran out
		summarize();
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20 && !pready; i++) @(posedge pclk);
		if (!pready) tmo();
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task item(input logic [2:0] k, input logic [15:0] d);
		int i;
		rsp_valid <= 1'b1;
		rsp_kind <= k;
		rsp_data <= d;
		@(posedge pclk);
		for (i = 0; i < 20 && !rsp_ready; i++) @(posedge pclk);
		if (!rsp_ready) tmo();
		rsp_valid <= 1'b0;
		@(posedge pclk);
		// ready comes back only once every byte has left
		for (i = 0; i < 50 && !rsp_ready; i++) @(posedge pclk);
		if (!rsp_ready) tmo();
	endtask
	task pop(input logic [7:0] e);
		chk(i_host.rx.pop_front(), e);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[r]) begin
			item(rows[r].k, rows[r].d);
			chk(i_host.rx.size(), rows[r].n);
			if (rows[r].n == 2'h2) pop(rows[r].e[15:8]);
			if (rows[r].n != 2'h0) pop(rows[r].e[7:0]);
		end
		$display("test items done");
		rd(8'h00, 32'h0);
		apb(1'b1, 8'h04, 32'h7f);
		rd(8'h04, 32'h2c);
		apb(1'b1, 8'h04, 32'h3b);
		item(3'h1, 16'h0);
		pop(8'h3b);
		apb(1'b0, 8'h18, 32'h0);
		chk(err, 1'b1);
		rd(8'h14, 32'h3);
		usb_hs <= 1'b0;
		rd(8'h14, 32'h2);
		$display("test registers done");
		i_host.send(8'h41);
		i_host.send(8'h00);
		repeat (2) @(posedge pclk);
		chk(last_cmd, 8'h41);
		chk(n_end, 1);
		chk(i_host.n_tmo, 0);
		rd(8'h08, 32'h0);
		chk(irq, 1'b0);
		$display("test command done");
		apb(1'b1, 8'h10, 32'h7);
		apb(1'b1, 8'h00, 32'h1);
		ev_status <= 7'h04;
		i_host.stall <= 1'b1;
		@(posedge pclk);
		ev_status <= 7'h00;
		item(3'h4, 16'h0);
		chk(i_host.rx.size(), 3);
		pop(8'h00);
		pop(8'h09);
		pop(8'h5a);
		chk(irq, 1'b1);
		rd(8'h0c, 32'h7);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, 8'h08, 32'h08);
		rd(8'h08, 32'h01);
		$display("test status form done");
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h00, 32'h0);
		item(3'h4, 16'h0);
		chk(i_host.rx.size(), 1);
		pop(8'h00);
		rd(8'h08, 32'h01);
		rd(8'h0c, 32'h2);
		$display("test reset done");
		summarize();
	end
endmodule // testbench

bind ucf_framer ucf_checker i_chk (.pclk, .presetn, .ep1_valid, .ep1_ready, .cmd_valid, .cmd_end,
	.rsp_valid, .rsp_ready, .ep2_valid, .ep2_ready, .ep1_data, .cmd_data, .ep2_data, .rsp_kind,
	.rsp_data);
